//--- core/vld_consts.svh
// Purpose: constants for the VME/local decoupling queue block
// Assumes: 32-bit register port, word index addresses
// Notes:   offsets are register indexes on the plain register port
`ifndef VLD_CONSTS_SVH
`define VLD_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define VLD_ADDR_DATAPATH_CONTROL_STATUS_REG      4'h0
`define VLD_ADDR_MODE      4'h1
`define VLD_ADDR_RECEIVE_OUTPUT_CONTROL_REG     4'h2
`define VLD_ADDR_RECEIVE_OUTPUT_ADDRESS_REG    4'h3
`define VLD_ADDR_RECEIVE_OUTPUT_DATA_REG    4'h4
`define VLD_ADDR_STAT      4'h5

// ----------------------------------------------------------------
// datapath control/status fields
// ----------------------------------------------------------------
`define VLD_DATAPATH_CONTROL_STATUS_REG_RECEIVE_QUEUE_RESET_BIT     0
`define VLD_DATAPATH_CONTROL_STATUS_REG_TRANSMIT_QUEUE_RESET_BIT     1
`define VLD_DATAPATH_CONTROL_STATUS_REG_RECEIVE_SHIFT_BIT    2
`define VLD_DATAPATH_CONTROL_STATUS_REG_LOCAL_BUS_ERROR_FLAG     3

// ----------------------------------------------------------------
// mode fields and reset value
// ----------------------------------------------------------------
`define VLD_MODE_COUPLED   0
`define VLD_MODE_BURST_EN  1
`define VLD_MODE_BLEN_LO   2
`define VLD_MODE_BLEN_HI   3
`define VLD_MODE_RECEIVE_DISABLE_BIT     4
`define VLD_MODE_TMO_LO    5
`define VLD_MODE_TMO_HI    6
`define VLD_MODE_RESET     7'h60

// ----------------------------------------------------------------
// receive entry control field positions
// ----------------------------------------------------------------
`define VLD_CTL_START      5
`define VLD_CTL_B64        4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define VLD_CLK_MHZ        200
`define VLD_TMO_16_US      16
`define VLD_TMO_16_CYC     (`VLD_TMO_16_US * `VLD_CLK_MHZ)
`define VLD_DRAIN_CYC      3

`endif

//--- core/vld_pkg.sv
// Purpose: types for the VME/local decoupling queue block
// Assumes: constants in vld_consts.svh
// Notes:   entry widths follow the receive and transmit queues
package vld_pkg;

  // ----------------------------------------------------------------
  // queue entries
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  ctl;
    logic [31:0] addr;
    logic [31:0] data;
    logic        spare;
  } vld_rx_entry_t;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [31:0] addr;
    logic [31:0] data;
  } vld_tx_entry_t;

  // ----------------------------------------------------------------
  // drain engine states, gray along idle-run-wait-done
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VLD_IDLE = 2'b00,
    VLD_RUN  = 2'b01,
    VLD_WAIT = 2'b11,
    VLD_DONE = 2'b10
  } vld_state_t;

  typedef enum logic [1:0] {
    VLD_OWN_NONE = 2'b00,
    VLD_OWN_EXT  = 2'b01,
    VLD_OWN_RX   = 2'b11,
    VLD_OWN_DMA  = 2'b10
  } vld_owner_t;

endpackage : vld_pkg

//--- core/vld_core.sv
// Purpose: VME slave / local bus decoupling queues with register port
// Assumes: one clock; vme and local handshakes are same-domain logic
//          except local ack and bus error lines, sampled on the falling edge
// Notes:   queue depth 15, pointers wrap modulo depth
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "vld_consts.svh"
`default_nettype none

module vld_core
  import vld_pkg::*;
#(
  parameter int DEPTH   = 15,
  parameter int TMO_CYC = `VLD_TMO_16_CYC
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  input  wire logic          vme_ds,
  input  wire logic          vme_write,
  input  wire logic          vme_decode_ok,
  input  wire logic          vme_protected,
  input  wire vld_rx_entry_t vme_entry,
  output logic               vme_dtack,
  output logic               vme_berr,
  output logic               vme_interrupt_output,
  input  wire logic          tx_wr,
  input  wire vld_tx_entry_t tx_entry,
  output logic               local_ack_outputs,
  input  wire logic          tx_pop,
  output logic               tx_valid,
  output vld_tx_entry_t      tx_head,
  input  wire logic          master_read_req,
  output logic               master_read_ok,
  input  wire logic          external_request_line_one,
  input  wire logic          fair_mode,
  input  wire logic          dma_req,
  output logic               dma_grant,
  output logic               ext_grant,
  output logic               lcl_req,
  output logic               lcl_burst,
  output vld_rx_entry_t      lcl_entry,
  input  wire logic          local_ack_inputs_n,
  input  wire logic          local_bus_error_line_n
);

  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][$bits(vld_rx_entry_t)-1:0] rxq;
    logic [DEPTH-1:0][$bits(vld_tx_entry_t)-1:0] txq;
    logic [PW-1:0]  rx_rd;
    logic [PW-1:0]  rx_wr;
    logic [PW:0]    rx_cnt;
    logic [PW-1:0]  tx_rd;
    logic [PW-1:0]  tx_wr;
    logic [PW:0]    tx_cnt;
    logic [6:0]     mode;
    logic           local_bus_error_flag;
    logic           coupled;
    vld_state_t     st;
    vld_owner_t     owner;
    logic [1:0]     pace;
    logic [5:0]     burst_cnt;
    logic [1:0]     ack_smp;
    logic [14:0]    tmo;
    logic           dtack;
    logic           berr;
    logic           lack;
    logic [31:0]    rdata;
  } vld_state_s_t;

  vld_state_s_t s_r;
  vld_state_s_t s_nxt;
  logic [1:0]   neg_smp_r;

  // local ack/error sampled on the falling edge; two lows end cycle
  always_ff @(negedge clk) begin
    if (!reset_n) begin
      neg_smp_r <= 2'b00;
    end else begin
      neg_smp_r <= {neg_smp_r[0],
                    ~(local_ack_inputs_n & local_bus_error_line_n)};
    end
  end

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic          rx_full;
  logic          rx_empty;
  logic          tx_full;
  vld_rx_entry_t rx_head;
  vld_rx_entry_t rx_next;
  logic [5:0]    blen;
  logic [14:0]   tmo_lim;
  logic          rx_run_ok;

  always_comb begin
    rx_full   = (s_r.rx_cnt == (PW+1)'(DEPTH));
    rx_empty  = (s_r.rx_cnt == '0);
    tx_full   = (s_r.tx_cnt == (PW+1)'(DEPTH));
    rx_head   = vld_rx_entry_t'(s_r.rxq[s_r.rx_rd]);
    rx_next   = vld_rx_entry_t'(s_r.rxq[(s_r.rx_rd == PW'(DEPTH-1)) ?
                                        '0 : s_r.rx_rd + PW'(1)]);
    case (s_r.mode[`VLD_MODE_BLEN_HI:`VLD_MODE_BLEN_LO])
      2'b00:   blen = 6'h04;
      2'b01:   blen = 6'h08;
      2'b10:   blen = 6'h10;
      default: blen = 6'h20;
    endcase
    case (s_r.mode[`VLD_MODE_TMO_HI:`VLD_MODE_TMO_LO])
      2'b01:   tmo_lim = 15'(TMO_CYC);
      2'b10:   tmo_lim = 15'(TMO_CYC * 2);
      default: tmo_lim = 15'(TMO_CYC * 4);
    endcase
    rx_run_ok = !rx_empty && !s_r.mode[`VLD_MODE_RECEIVE_DISABLE_BIT];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic push_rx;
  logic pop_rx;
  logic push_tx;
  logic pop_tx;
  logic b64;
  logic start_burst;
  logic cpl_end;
  logic cpl_go;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.dtack = 1'b0;
    s_nxt.lack  = 1'b0;
    push_rx     = 1'b0;
    pop_rx      = 1'b0;
    pop_tx      = 1'b0;
    cpl_go      = 1'b0;
    cpl_end     = (neg_smp_r == 2'b11);
    b64         = rx_head.ctl[`VLD_CTL_B64];
    // queue holds enough entries for a burst of the head entry's type
    start_burst = s_r.mode[`VLD_MODE_BURST_EN] &&
                  (b64 ? (s_r.rx_cnt >= (PW+1)'(2)) :
                         (s_r.rx_cnt >= (PW+1)'(4)));

    // coupled mode only after receive queue drained
    if (!s_r.mode[`VLD_MODE_COUPLED]) begin
      s_nxt.coupled = 1'b0;
    end else if (rx_empty) begin
      s_nxt.coupled = 1'b1;
    end

    // bus timer runs while data strobe is asserted
    if (!vme_ds) begin
      s_nxt.tmo  = '0;
      s_nxt.berr = 1'b0;
    end else if (s_r.mode[`VLD_MODE_TMO_HI:`VLD_MODE_TMO_LO] != 2'b00 &&
                 !s_r.berr && !s_r.dtack) begin
      s_nxt.tmo = s_r.tmo + 15'(1);
      if (s_r.tmo >= tmo_lim) begin
        s_nxt.berr = 1'b1;
      end
    end

    // vme slave side
    if (vme_ds && !s_r.berr && !s_r.dtack && s_r.st == VLD_IDLE) begin
      if (vme_protected) begin
        s_nxt.berr = 1'b1;
      end else if (vme_decode_ok && vme_write && !s_r.coupled &&
                   !rx_full) begin
        push_rx     = 1'b1;
        s_nxt.dtack = 1'b1;
        if (s_r.mode[`VLD_MODE_RECEIVE_DISABLE_BIT]) begin
          s_nxt.local_bus_error_flag = 1'b1;
        end
      end else if (vme_decode_ok && (s_r.coupled || !vme_write) &&
                   rx_empty) begin
        cpl_go = 1'b1;
      end
    end

    // local bus arbiter
    if (s_r.owner == VLD_OWN_NONE || s_r.owner == VLD_OWN_EXT ||
        s_r.owner == VLD_OWN_DMA) begin
      if (external_request_line_one && !fair_mode) begin
        s_nxt.owner = VLD_OWN_EXT;
      end else if (rx_run_ok || cpl_go) begin
        // coupled cycles claim the bus here, so the arbiter cannot drop them
        s_nxt.owner     = VLD_OWN_RX;
        s_nxt.st        = cpl_go ? VLD_WAIT : VLD_RUN;
        s_nxt.pace      = '0;
        s_nxt.burst_cnt = '0;
      end else if (dma_req) begin
        s_nxt.owner = VLD_OWN_DMA;
      end else begin
        s_nxt.owner = VLD_OWN_NONE;
      end
    end else begin
      case (s_r.st)
        VLD_RUN: begin
          // one longword every three clocks, or every clock while start_burst holds
          s_nxt.pace = s_r.pace + 2'(1);
          if (start_burst || s_r.pace == 2'(`VLD_DRAIN_CYC - 1)) begin
            pop_rx          = 1'b1;
            s_nxt.pace      = '0;
            s_nxt.burst_cnt = s_r.burst_cnt + 6'(1);
            // hold the bus until empty; a burst also ends on type or
            // length
            if (s_r.rx_cnt == (PW+1)'(1) || (start_burst &&
                (rx_next.ctl[`VLD_CTL_B64] != b64 ||
                 s_r.burst_cnt + 6'(1) >= blen))) begin
              s_nxt.st = VLD_DONE;
            end
          end
          if (!rx_run_ok) begin
            s_nxt.st = VLD_DONE;
          end
        end
        VLD_WAIT: begin
          if (cpl_end) begin
            s_nxt.dtack = 1'b1;
            s_nxt.st    = VLD_DONE;
          end
        end
        VLD_DONE: begin
          s_nxt.st    = VLD_IDLE;
          s_nxt.owner = VLD_OWN_NONE;
        end
        default: begin
          s_nxt.st    = VLD_IDLE;
          s_nxt.owner = VLD_OWN_NONE;
        end
      endcase
    end

    // transmit queue
    push_tx = tx_wr && !tx_full;
    pop_tx  = tx_pop && (s_r.tx_cnt != '0);
    if (push_tx) begin
      s_nxt.txq[s_r.tx_wr] = tx_entry;
      s_nxt.tx_wr = (s_r.tx_wr == PW'(DEPTH-1)) ? '0 : s_r.tx_wr + PW'(1);
      s_nxt.lack  = 1'b1;
    end
    if (pop_tx) begin
      s_nxt.tx_rd = (s_r.tx_rd == PW'(DEPTH-1)) ? '0 : s_r.tx_rd + PW'(1);
    end
    s_nxt.tx_cnt = s_r.tx_cnt + (PW+1)'(push_tx) - (PW+1)'(pop_tx);

    // register port; shift discards the oldest entry
    if (reg_wr && reg_addr == `VLD_ADDR_DATAPATH_CONTROL_STATUS_REG &&
        reg_wdata[`VLD_DATAPATH_CONTROL_STATUS_REG_RECEIVE_SHIFT_BIT] && !rx_empty) begin
      pop_rx = 1'b1;
    end
    if (reg_wr && reg_addr == `VLD_ADDR_MODE) begin
      s_nxt.mode = reg_wdata[6:0];
    end
    // hardware set wins over software clear
    if (reg_wr && reg_addr == `VLD_ADDR_DATAPATH_CONTROL_STATUS_REG &&
        reg_wdata[`VLD_DATAPATH_CONTROL_STATUS_REG_LOCAL_BUS_ERROR_FLAG] && !(push_rx &&
        s_r.mode[`VLD_MODE_RECEIVE_DISABLE_BIT])) begin
      s_nxt.local_bus_error_flag = 1'b0;
    end

    if (push_rx) begin
      s_nxt.rxq[s_r.rx_wr] = vme_entry;
      s_nxt.rx_wr = (s_r.rx_wr == PW'(DEPTH-1)) ? '0 : s_r.rx_wr + PW'(1);
    end
    if (pop_rx) begin
      s_nxt.rx_rd = (s_r.rx_rd == PW'(DEPTH-1)) ? '0 : s_r.rx_rd + PW'(1);
    end
    s_nxt.rx_cnt = s_r.rx_cnt + (PW+1)'(push_rx) - (PW+1)'(pop_rx);

    // queue resets override pointer moves
    if (reg_wr && reg_addr == `VLD_ADDR_DATAPATH_CONTROL_STATUS_REG) begin
      if (reg_wdata[`VLD_DATAPATH_CONTROL_STATUS_REG_RECEIVE_QUEUE_RESET_BIT]) begin
        s_nxt.rx_rd  = '0;
        s_nxt.rx_wr  = '0;
        s_nxt.rx_cnt = '0;
      end
      if (reg_wdata[`VLD_DATAPATH_CONTROL_STATUS_REG_TRANSMIT_QUEUE_RESET_BIT]) begin
        s_nxt.tx_rd  = '0;
        s_nxt.tx_wr  = '0;
        s_nxt.tx_cnt = '0;
      end
    end

    // read data one cycle later
    s_nxt.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `VLD_ADDR_DATAPATH_CONTROL_STATUS_REG:   s_nxt.rdata = 32'(s_r.local_bus_error_flag) << `VLD_DATAPATH_CONTROL_STATUS_REG_LOCAL_BUS_ERROR_FLAG;
        `VLD_ADDR_MODE:   s_nxt.rdata = 32'(s_r.mode);
        `VLD_ADDR_RECEIVE_OUTPUT_CONTROL_REG:  s_nxt.rdata = 32'(rx_head.ctl);
        `VLD_ADDR_RECEIVE_OUTPUT_ADDRESS_REG: s_nxt.rdata = rx_head.addr;
        `VLD_ADDR_RECEIVE_OUTPUT_DATA_REG: s_nxt.rdata = rx_head.data;
        `VLD_ADDR_STAT:   s_nxt.rdata = (32'(s_r.tx_cnt) << 16) |
                                        (32'(s_r.rx_cnt) << 8) |
                                        32'(s_r.coupled);
        default:          s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r      <= '0;
      s_r.mode <= `VLD_MODE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata            = s_r.rdata;
  assign vme_dtack            = s_r.dtack;
  assign vme_berr             = s_r.berr;
  assign vme_interrupt_output = s_r.local_bus_error_flag;
  assign local_ack_outputs    = s_r.lack;
  assign tx_valid             = (s_r.tx_cnt != '0);
  assign tx_head              = vld_tx_entry_t'(s_r.txq[s_r.tx_rd]);
  assign master_read_ok       = master_read_req &&
                                (s_r.tx_cnt == '0);
  assign ext_grant            = (s_r.owner == VLD_OWN_EXT);
  assign dma_grant            = (s_r.owner == VLD_OWN_DMA);
  assign lcl_req              = (s_r.owner == VLD_OWN_RX);
  assign lcl_burst            = lcl_req && s_r.st == VLD_RUN &&
                                start_burst;
  assign lcl_entry            = rx_head;

endmodule : vld_core

`default_nettype wire

//--- tb/vld_sva.sv
// Purpose: port assertions for vld_core
// Assumes: one clock, sync active low reset
// Notes:   bound to every vld_core instance
`timescale 1ns/10ps
`default_nettype none
module vld_sva
  import vld_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        vme_ds,
  input wire logic        vme_dtack,
  input wire logic        vme_berr,
  input wire logic        tx_wr,
  input wire logic        local_ack_outputs,
  input wire logic        tx_valid,
  input wire logic        master_read_req,
  input wire logic        master_read_ok,
  input wire logic        external_request_line_one,
  input wire logic        fair_mode,
  input wire logic        dma_grant,
  input wire logic        ext_grant,
  input wire logic        lcl_req,
  input wire logic        lcl_burst
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_dtack_pulse: assert property (vme_dtack |=> !vme_dtack)
    else $error("vme ack longer than one cycle");
  a_dtack_cause: assert property (vme_dtack |-> $past(vme_ds))
    else $error("vme ack without strobe");
  a_berr_hold: assert property (vme_berr && vme_ds |=> vme_berr)
    else $error("vme bus error dropped early");
  a_answer_excl: assert property (!(vme_dtack && vme_berr))
    else $error("ack and bus error together");
  a_lack_cause: assert property (local_ack_outputs |-> $past(tx_wr))
    else $error("local ack without queued write");
  a_mread_gate: assert property (master_read_ok ==
      (master_read_req && !tx_valid))
    else $error("master read gate wrong");
  a_grant_onehot: assert property ($onehot0(
      {ext_grant, dma_grant, lcl_req}))
    else $error("two local bus owners");
  a_dma_last: assert property ($rose(dma_grant) |->
      !($past(external_request_line_one) && !$past(fair_mode)))
    else $error("dma granted over external request");
  a_burst_owned: assert property (lcl_burst |-> lcl_req)
    else $error("burst without local bus");
endmodule : vld_sva

bind vld_core vld_sva vld_sva_inst (
  .clk(clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .vme_ds(vme_ds), .vme_dtack(vme_dtack), .vme_berr(vme_berr),
  .tx_wr(tx_wr), .local_ack_outputs(local_ack_outputs),
  .tx_valid(tx_valid), .master_read_req(master_read_req),
  .master_read_ok(master_read_ok),
  .external_request_line_one(external_request_line_one),
  .fair_mode(fair_mode), .dma_grant(dma_grant), .ext_grant(ext_grant),
  .lcl_req(lcl_req), .lcl_burst(lcl_burst)
);
`default_nettype wire

//--- tb/vld_mem_model.sv
// Purpose: local memory answering drain cycles
// Assumes: request held until answered
// Notes:   wait states and error reply set by the bench
`timescale 1ns/10ps
`default_nettype none
module vld_mem_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       lcl_req,
  input  wire logic [3:0] wait_cyc,
  input  wire logic       give_err,
  output logic            ack_n,
  output logic            err_n
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    if (!reset_n || !lcl_req) cnt_r <= 4'h0;
    else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
  end
  // pulled-up lines: idle reads high, zero wait answers at once
  assign ack_n = !(lcl_req && cnt_r >= wait_cyc && !give_err);
  assign err_n = !(lcl_req && cnt_r >= wait_cyc && give_err);
endmodule : vld_mem_model
`default_nettype wire

//--- tb/tb_vme_local_decoupling_fifos.sv
// Purpose: self-checking bench for vld_core
// Assumes: short bus timer (TMO_CYC 20)
// Notes:   table of vme cycles, then hand tests
`timescale 1ns/10ps
`include "vld_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module tb_vme_local_decoupling_fifos;
  import vld_pkg::*;
  logic clk, reset_n, reg_wr, reg_rd, vme_ds, vme_write, vme_decode_ok;
  logic vme_protected, vme_dtack, vme_berr, irq, tx_wr, tx_pop, tx_valid;
  logic lack, mrd_req, mrd_ok, ext_req, fair_mode, dma_req, dma_grant;
  logic ext_grant, lcl_req, lcl_burst, ack_n, err_n, give_err, got_d;
  logic got_b;
  logic [3:0] reg_addr, wait_cyc;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  vld_rx_entry_t vme_entry, lcl_entry;
  vld_tx_entry_t tx_entry, tx_head;
  logic [3:0] rows [4] = '{4'b1101, 4'b1110, 4'b1000, 4'b0101};
  int n_mismatch, samples_checked, cyc, i, k, lat;

  vld_core #(.DEPTH(15), .TMO_CYC(20)) vld_core_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vme_ds(vme_ds), .vme_write(vme_write),
    .vme_decode_ok(vme_decode_ok), .vme_protected(vme_protected),
    .vme_entry(vme_entry), .vme_dtack(vme_dtack), .vme_berr(vme_berr),
    .vme_interrupt_output(irq), .tx_wr(tx_wr), .tx_entry(tx_entry),
    .local_ack_outputs(lack), .tx_pop(tx_pop), .tx_valid(tx_valid),
    .tx_head(tx_head), .master_read_req(mrd_req),
    .master_read_ok(mrd_ok), .external_request_line_one(ext_req),
    .fair_mode(fair_mode), .dma_req(dma_req), .dma_grant(dma_grant),
    .ext_grant(ext_grant), .lcl_req(lcl_req), .lcl_burst(lcl_burst),
    .lcl_entry(lcl_entry), .local_ack_inputs_n(ack_n),
    .local_bus_error_line_n(err_n));
  vld_mem_model vld_mem_model_inst (.clk(clk), .reset_n(reset_n),
    .lcl_req(lcl_req), .wait_cyc(wait_cyc), .give_err(give_err),
    .ack_n(ack_n), .err_n(err_n));

  // ----------------------------------------------------------------
  // clock, timeout, tasks
  // ----------------------------------------------------------------
  initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin n_mismatch++; give_verdict(); end
  end
  task give_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask : reg_w
  task reg_r(input logic [3:0] a);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : reg_r
  function automatic vld_rx_entry_t ent(logic [5:0] c, logic [31:0] d);
    return '{c, 32'h10000000 + d, d, 1'b0};
  endfunction : ent
  // strobe held until ack or bus error is sampled or lim cycles pass, then dropped
  task vme_cyc(input logic w, ok, pr, input vld_rx_entry_t e, int lim);
    got_d = 1'b0; got_b = 1'b0; lat = 0;
    @(posedge clk); vme_ds <= 1'b1; vme_write <= w;
    vme_decode_ok <= ok; vme_protected <= pr; vme_entry <= e;
    while (!got_d && !got_b && lat < lim) begin
      @(posedge clk); lat++;
      got_d = (vme_dtack === 1'b1); got_b = (vme_berr === 1'b1);
    end
    vme_ds <= 1'b0;
  endtask : vme_cyc
  task tx_put(input int n);
    @(posedge clk); tx_wr <= 1'b1;
    tx_entry <= '{8'h10 + n[7:0], 32'h20000000 + n, 32'hC0 + n};
    @(posedge clk); tx_wr <= 1'b0;
    #1 got_d = lack;
  endtask : tx_put
  task wait_for(input logic [3:0] a, input logic [31:0] v);
    k = 0;
    while (lcl_entry.data !== v && k < 60) begin @(posedge clk); k++; end
  endtask : wait_for

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, vme_ds, vme_write, vme_decode_ok} = '0;
    {vme_protected, tx_wr, tx_pop, mrd_req, ext_req, fair_mode} = '0;
    {dma_req, give_err, reg_addr, wait_cyc, reg_wdata} = '0;
    vme_entry = '0; tx_entry = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    reg_r(`VLD_ADDR_MODE); `CHK("mode", 32'h60, rd_v)
    reg_r(4'hF); `CHK("unmapped", 32'h0, rd_v)
    reg_r(`VLD_ADDR_STAT); `CHK("stat", 32'h0, rd_v)
    for (i = 0; i < 4; i++) begin
      vme_cyc(rows[i][3], rows[i][2], rows[i][1], ent(6'h0C, i), 200);
      `CHK("dtack", rows[i][0], got_d)
      `CHK("berr", !rows[i][0], got_b)
    end
    reg_w(`VLD_ADDR_MODE, 32'h70);
    for (i = 0; i < 15; i++) begin
      vme_cyc(1'b1, 1'b1, 1'b0, ent(6'h0C, 32'hA0 + i), 50);
      `CHK("fill", 1'b1, got_d)
    end
    `CHK("irq", 1'b1, irq)
    vme_cyc(1'b1, 1'b1, 1'b0, ent(6'h0C, 32'hAF), 200);
    `CHK("full", 1'b1, got_b)
    reg_r(`VLD_ADDR_RECEIVE_OUTPUT_CONTROL_REG); `CHK("ctl", 32'h0C, rd_v)
    reg_r(`VLD_ADDR_RECEIVE_OUTPUT_ADDRESS_REG); `CHK("addr", 32'h100000A0, rd_v)
    reg_w(`VLD_ADDR_DATAPATH_CONTROL_STATUS_REG, 32'h4);
    reg_r(`VLD_ADDR_RECEIVE_OUTPUT_DATA_REG); `CHK("shift", 32'hA1, rd_v)
    reg_r(`VLD_ADDR_STAT); `CHK("cnt", 4'hE, rd_v[11:8])
    reg_w(`VLD_ADDR_DATAPATH_CONTROL_STATUS_REG, 32'h9);
    reg_r(`VLD_ADDR_STAT); `CHK("receive_queue_reset_bit", 4'h0, rd_v[11:8])
    `CHK("irq clr", 1'b0, irq)
    for (i = 0; i < 3; i++)
      vme_cyc(1'b1, 1'b1, 1'b0, ent(6'h0C, 32'hB0 + i), 50);
    vme_cyc(1'b0, 1'b1, 1'b0, ent(6'h0C, 32'h0), 12);
    `CHK("rd held", 1'b0, got_d)
    reg_w(`VLD_ADDR_MODE, 32'h60);
    wait_for(4'h0, 32'hB1); wait_for(4'h0, 32'hB2);
    `CHK("drain", 3, k)
    vme_cyc(1'b0, 1'b1, 1'b0, ent(6'h0C, 32'h0), 100);
    `CHK("rd done", 1'b1, got_d)
    tx_put(0); `CHK("lack", 1'b1, got_d)
    @(posedge clk); mrd_req <= 1'b1;
    @(posedge clk); #1 `CHK("mrd", 1'b0, mrd_ok)
    for (i = 1; i < 16; i++) tx_put(i);
    `CHK("tx full", 1'b0, got_d)
    @(posedge clk); tx_pop <= 1'b1;
    @(posedge clk); tx_pop <= 1'b0;
    #1 `CHK("txhead", 32'hC1, tx_head.data)
    reg_w(`VLD_ADDR_DATAPATH_CONTROL_STATUS_REG, 32'h2);
    #1 `CHK("transmit_queue_reset_bit", 1'b1, mrd_ok)
    @(posedge clk); ext_req <= 1'b1; dma_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("ext", 2'b10, {ext_grant, dma_grant})
    @(posedge clk); ext_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK("dma", 1'b1, dma_grant)
    @(posedge clk); dma_req <= 1'b0; wait_cyc <= 4'h6;
    // coupled bit changed only while no slave cycle is open
    reg_w(`VLD_ADDR_MODE, 32'h61);
    vme_cyc(1'b1, 1'b1, 1'b0, ent(6'h0C, 32'hD0), 100);
    `CHK("cpl", 1'b1, got_d && lat > 6)
    @(posedge clk); give_err <= 1'b1;
    vme_cyc(1'b1, 1'b1, 1'b0, ent(6'h0C, 32'hD1), 100);
    `CHK("cpl err", 1'b1, got_d)
    @(posedge clk); give_err <= 1'b0; wait_cyc <= 4'h0;
    reg_w(`VLD_ADDR_MODE, 32'h72);
    for (i = 0; i < 4; i++)
      vme_cyc(1'b1, 1'b1, 1'b0, ent(i == 0 ? 6'h2C : 6'h0C, i), 50);
    reg_w(`VLD_ADDR_MODE, 32'h62);
    got_b = 1'b0;
    repeat (30) @(posedge clk) if (lcl_burst === 1'b1) got_b = 1'b1;
    `CHK("burst", 1'b1, got_b)
    // mid-run reset: flag, mode and counts go back to defaults
    @(posedge clk); reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    #1 `CHK("rst irq", 1'b0, irq)
    reg_r(`VLD_ADDR_MODE); `CHK("rst mode", 32'h60, rd_v)
    reg_r(`VLD_ADDR_STAT); `CHK("rst stat", 32'h0, rd_v)
    give_verdict();
  end
endmodule : tb_vme_local_decoupling_fifos
`default_nettype wire
